// File: csp_top.v
// clocked serial port: apb registers, clock generation and shift engine
`timescale 1ns/1ps
`include "csp_map.vh"
module csp_top (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        sclkIn,
  output reg         sclkOut,
  output reg         sclkOe,
  input  wire        sdi,
  output reg         sdo,
  output reg         doneIrq
);
  localparam ST_IDLE  = 4'b0001;
  localparam ST_LOAD  = 4'b0010;
  localparam ST_SHIFT = 4'b0100;
  localparam ST_WAIT  = 4'b1000;

  reg  [3:0]  state;
  reg         start;
  reg  [2:0]  mode;
  reg  [2:0]  clkSel;
  reg  [2:0]  wordCnt;
  reg         active;
  reg  [7:0]  sh;
  reg  [2:0]  bitCnt;
  reg  [2:0]  idx;
  reg         dummy;
  reg         written;
  reg         unread;
  reg  [12:0] pre;
  reg         sckS1;
  reg         sckS2;
  reg         sckS3;
  reg         sdiS1;
  reg         sdiS2;
  reg         accd;
  reg  [3:0]  halfLog;
  wire [7:0]  memRdata;

  // apb decode
  wire        isBuf   = paddr[7:5] == `CSP_BUF_SEL;
  wire [2:0]  bufIdx  = paddr[4:2];
  wire        isReg   = paddr == `CSP_ADDR_CTRL1 || paddr == `CSP_ADDR_CTRL2 ||
                        paddr == `CSP_ADDR_STAT;
  wire        mapped  = (isBuf && paddr[1:0] == 2'h0) || isReg;
  wire        wrCyc   = psel && penable && pready && pwrite;
  wire        rdCyc   = psel && penable && pready && !pwrite;
  wire        ctrl1Wr = wrCyc && paddr == `CSP_ADDR_CTRL1;
  wire        ctrl2Wr = wrCyc && paddr == `CSP_ADDR_CTRL2;
  wire        bufWr   = wrCyc && isBuf && mapped;
  wire        bufRd   = rdCyc && isBuf && mapped;
  wire [2:0]  newMode = pwdata[`CSP_C1_MODE_HI:`CSP_C1_MODE_LO];

  // mode decode
  wire isTx  = mode == `CSP_MODE_TX8 || mode == `CSP_MODE_TX4 || mode == `CSP_MODE_TXRX8;
  wire isRx  = mode == `CSP_MODE_RX8 || mode == `CSP_MODE_RX4 || mode == `CSP_MODE_TXRX8;
  wire four  = mode == `CSP_MODE_TX4 || mode == `CSP_MODE_RX4;
  wire ext   = clkSel == `CSP_CLK_EXT;
  wire clkOk = clkSel <= `CSP_CLK_FAST_MAX || ext;

  wire abortNow = ctrl1Wr && pwdata[`CSP_C1_ABORT];
  wire startNow = ctrl1Wr && pwdata[`CSP_C1_START] && !pwdata[`CSP_C1_ABORT] &&
                  state == ST_IDLE && (newMode == mode) && clkOk;

  always @* begin
    if (clkSel == `CSP_CLK_SLOW) begin
      halfLog = `CSP_SLOW_HALF_LOG2;
    end else begin
      halfLog = `CSP_FAST_HALF_BASE - {1'b0, clkSel};
    end
  end
  wire [12:0] halfMask = ~(13'h1FFF << halfLog);
  wire        intTick  = (pre & halfMask) == halfMask;
  wire        shifting = state == ST_SHIFT;

  // leading edge is the falling pin edge
  wire fallE = shifting && (ext ? (sckS3 && !sckS2) : (intTick && sclkOut));
  // trailing edge is the rising pin edge
  wire riseE = shifting && (ext ? (!sckS3 && sckS2) : (intTick && !sclkOut));

  // nibble mode shifts into bit 3, upper nibble zero
  wire [7:0] nextSh = four ? {4'h0, sdiS2, sh[3:1]} : {sdiS2, sh[7:1]};
  wire [2:0] lastBit  = four ? 3'h3 : 3'h7;
  wire       wordDone = riseE && bitCnt == lastBit;
  // burst length from the count field
  wire       lastWord = idx == wordCnt;
  wire       extDrop  = ext && isRx && unread;
  wire       stopNow  = dummy || !start;
  wire       contMid  = wordDone && !extDrop && !stopNow && !lastWord;
  wire       contExt  = wordDone && !extDrop && !stopNow && lastWord && ext;
  // wait ends on a write (transmit) and a read (receive); transmit-receive needs both
  wire       waitDone = (!isTx || written) && (!isRx || !unread);
  wire       waitGo   = state == ST_WAIT && start && waitDone && !abortNow;
  wire       engRd    = startNow || contMid || contExt || waitGo;
  wire [2:0] engAddr  = contMid ? idx + 3'h1 : 3'h0;
  wire       rxStore  = wordDone && isRx && !extDrop && !abortNow;
  wire       memWe    = rxStore || bufWr;
  wire [2:0] memWaddr = rxStore ? idx : bufIdx;
  wire [7:0] memWdata = rxStore ? nextSh : pwdata[7:0];
  wire       memClr   = ctrl1Wr && newMode != mode;
  wire       apbAcc   = psel && penable && !pready && !accd && !engRd;

  csp_buf uBuf (
    .clk   (clk),
    .rst_n (rst_n),
    .clr   (memClr),
    .we    (memWe),
    .waddr (memWaddr),
    .wdata (memWdata),
    .raddr (engRd ? engAddr : bufIdx),
    .rdata (memRdata)
  );

  // pin synchronisers and prescaler
  always @(posedge clk) begin
    if (!rst_n) begin
      sckS1 <= 1'b1;
      sckS2 <= 1'b1;
      sckS3 <= 1'b1;
      sdiS1 <= 1'b0;
      sdiS2 <= 1'b0;
      pre   <= 13'h0000;
    end else begin
      sckS1 <= sclkIn;
      sckS2 <= sckS1;
      sckS3 <= sckS2;
      sdiS1 <= sdi;
      sdiS2 <= sdiS1;
      pre   <= pre + 13'h0001;
    end
  end

  // apb slave
  always @(posedge clk) begin
    if (!rst_n) begin
      accd    <= 1'b0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      accd   <= apbAcc;
      pready <= accd;
      if (accd) begin
        pslverr <= !mapped;
        if (!mapped || pwrite) begin
          prdata <= 32'h00000000;
        end else if (isBuf) begin
          prdata <= {24'h000000, memRdata};
        end else if (paddr == `CSP_ADDR_CTRL1) begin
          prdata <= {24'h000000, start, 1'b0, mode, clkSel};
        end else if (paddr == `CSP_ADDR_CTRL2) begin
          prdata <= {29'h00000000, wordCnt};
        end else begin
          prdata <= {24'h000000, active, state != ST_IDLE && state != ST_WAIT, 6'h00};
        end
      end
    end
  end

  // control registers
  wire [7:0] ctrl1Rst = `CSP_CTRL1_RST;
  always @(posedge clk) begin
    if (!rst_n) begin
      start   <= ctrl1Rst[`CSP_C1_START];
      mode    <= ctrl1Rst[`CSP_C1_MODE_HI:`CSP_C1_MODE_LO];
      clkSel  <= ctrl1Rst[`CSP_C1_CLK_HI:`CSP_C1_CLK_LO];
      wordCnt <= `CSP_CTRL2_RST;
    end else begin
      if (ctrl1Wr) begin
        start  <= pwdata[`CSP_C1_START] && !pwdata[`CSP_C1_ABORT];
        mode   <= newMode;
        clkSel <= pwdata[`CSP_C1_CLK_HI:`CSP_C1_CLK_LO];
      end
      if (ctrl2Wr) begin
        wordCnt <= pwdata[`CSP_C2_CNT_HI:`CSP_C2_CNT_LO];
      end
    end
  end

  // pin drive mode
  always @(posedge clk) begin
    if (!rst_n) begin
      sclkOe <= 1'b0;
    end else begin
      sclkOe <= !ext && state != ST_IDLE && !abortNow;
    end
  end

  // shift engine
  always @(posedge clk) begin
    if (!rst_n) begin
      state   <= ST_IDLE;
      active  <= 1'b0;
      sh      <= 8'h00;
      bitCnt  <= 3'h0;
      idx     <= 3'h0;
      dummy   <= 1'b0;
      written <= 1'b0;
      unread  <= 1'b0;
      sclkOut <= 1'b1;
      sdo     <= 1'b1;
      doneIrq <= 1'b0;
    end else begin
      doneIrq <= 1'b0;
      if (bufWr) begin
        written <= 1'b1;
      end
      if (bufRd) begin
        unread <= 1'b0;
      end
      if (abortNow) begin
        state   <= ST_IDLE;
        active  <= 1'b0;
        dummy   <= 1'b0;
        sclkOut <= 1'b1;
      end else begin
        case (state)
          ST_IDLE: begin
            sclkOut <= 1'b1;
            if (startNow) begin
              active  <= 1'b1;
              idx     <= 3'h0;
              unread  <= 1'b0;
              written <= bufWr;
              state   <= ST_LOAD;
            end
          end
          ST_LOAD: begin
            sh     <= dummy ? `CSP_DUMMY : memRdata;
            bitCnt <= 3'h0;
            state  <= ST_SHIFT;
          end
          ST_SHIFT: begin
            if (!ext && intTick) begin
              sclkOut <= !sclkOut;
            end
            if (fallE) begin
              sdo <= sh[0];
            end
            if (riseE) begin
              sh     <= nextSh;
              bitCnt <= bitCnt + 3'h1;
            end
            if (wordDone) begin
              if (extDrop || stopNow) begin
                state  <= ST_IDLE;
                active <= 1'b0;
                dummy  <= 1'b0;
              end else if (!lastWord) begin
                idx   <= idx + 3'h1;
                state <= ST_LOAD;
              end else begin
                doneIrq <= 1'b1;
                unread  <= isRx;
                idx     <= 3'h0;
                if (!ext) begin
                  state <= ST_WAIT;
                end else begin
                  // no new data: send dummy then end
                  dummy   <= isTx && !written && !bufWr;
                  written <= bufWr;
                  state   <= ST_LOAD;
                end
              end
            end
          end
          ST_WAIT: begin
            sclkOut <= 1'b1;
            if (!start) begin
              state  <= ST_IDLE;
              active <= 1'b0;
            end else if (waitGo) begin
              written <= bufWr;
              state   <= ST_LOAD;
            end
          end
          default: begin
            state  <= ST_IDLE;
            active <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule

// File: csp_map.vh
// constants of the clocked serial port, with its behaviour list
// Behaviour
// - clock code 000 slowest, 001-101 divide 256 to 16, 110 unused, 111 external
// - internal clock drives the clock pin, which is high when a transfer begins
// - outgoing bits change on the clock falling edge
// - incoming bits are sampled and shifted on the clock rising edge
// - 4-bit words use the low nibble; received upper nibble is zero
// - every word shifts least significant bit first
// - one to eight words per burst, count from the word count field
// - transmit loads the next buffer word right after the current last bit
// - transmit raises the done pulse when the burst has been sent
// - internal transmit waits with clock stopped until any word is written
// - a write to any buffer, in use or not, ends a transmit wait
// - clearing start lets the current word finish, then active drops
// - abort ends the transfer at once and drops active
// - external transmit without new data sends dummy data, then ends
// - receive stores each word in the next buffer, done pulse when full
// - internal receive waits with clock stopped until any word is read
// - a read of any buffer, in use or not, ends a receive wait
// - external receive with unread data drops the word and ends
// - clearing start in receive stores the current word, then ends
// - changing the transfer mode clears the buffer contents
// - after start clears, active drops at the end or on abort
// - buffers are used from the lowest index upward
`ifndef CSP_MAP_VH
`define CSP_MAP_VH
`define CSP_ADDR_CTRL1   8'h00
`define CSP_ADDR_CTRL2   8'h04
`define CSP_ADDR_STAT    8'h08
`define CSP_BUF_SEL      3'h1
`define CSP_C1_START     7
`define CSP_C1_ABORT     6
`define CSP_C1_MODE_HI   5
`define CSP_C1_MODE_LO   3
`define CSP_C1_CLK_HI    2
`define CSP_C1_CLK_LO    0
`define CSP_C2_CNT_HI    2
`define CSP_C2_CNT_LO    0
`define CSP_ST_ACTIVE    7
`define CSP_ST_SHIFT     6
`define CSP_CTRL1_RST    8'h00
`define CSP_CTRL2_RST    3'h0
`define CSP_MODE_TX8     3'h0
`define CSP_MODE_TX4     3'h2
`define CSP_MODE_TXRX8   3'h4
`define CSP_MODE_RX8     3'h5
`define CSP_MODE_RX4     3'h6
`define CSP_CLK_SLOW     3'h0
`define CSP_CLK_FAST_MAX 3'h5
`define CSP_CLK_EXT      3'h7
`define CSP_SLOW_HALF_LOG2 4'hC
`define CSP_FAST_HALF_BASE 4'h8
`define CSP_DUMMY        8'hFF
`endif

// File: csp_buf.v
// eight-entry data buffer bank with registered read port
`timescale 1ns/1ps
module csp_buf (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       clr,
  input  wire       we,
  input  wire [2:0] waddr,
  input  wire [7:0] wdata,
  input  wire [2:0] raddr,
  output reg  [7:0] rdata
);
  wire [7:0] ent [0:7];
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : gEnt
      reg [7:0] word;
      always @(posedge clk) begin
        if (!rst_n || clr) begin
          word <= 8'h00;
        end else if (we && waddr == i) begin
          word <= wdata;
        end
      end
      assign ent[i] = word;
    end
  endgenerate
  always @(posedge clk) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= ent[raddr];
    end
  end
endmodule

// File: csp_top_properties.sv
// assertions on the serial port top ports
`timescale 1ns/1ps
`include "csp_map.vh"
module csp_top_properties (
  input wire        clk,
  input wire        rst_n,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        sclkIn,
  input wire        sclkOut,
  input wire        sclkOe,
  input wire        sdi,
  input wire        sdo,
  input wire        doneIrq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire badAddr = (paddr[1:0] != 2'h0) || (paddr > 8'h3C) || ((paddr > 8'h08) && (paddr < 8'h20));
  property p_readyPulse; pready |=> !pready; endproperty
  a_readyPulse: assert property (p_readyPulse) else $error("pready longer than one cycle");
  property p_readyReq; pready |-> psel && penable; endproperty
  a_readyReq: assert property (p_readyReq) else $error("pready without access phase");
  property p_errMap; pready |-> (pslverr == badAddr); endproperty
  a_errMap: assert property (p_errMap) else $error("pslverr does not match address");
  property p_donePulse; doneIrq |=> !doneIrq; endproperty
  a_donePulse: assert property (p_donePulse) else $error("done pulse too long");
  property p_idleHigh; !sclkOe |-> sclkOut; endproperty
  a_idleHigh: assert property (p_idleHigh) else $error("clock not high when idle");
  property p_sdoHold; sclkOe && $rose(sclkOut) |-> $stable(sdo); endproperty
  a_sdoHold: assert property (p_sdoHold) else $error("data changed at rising clock");
  property p_halfMin;
    sclkOe && $changed(sclkOut) |=> (!sclkOe || $stable(sclkOut))[*7];
  endproperty
  a_halfMin: assert property (p_halfMin) else $error("clock half period too short");
  property p_abortStop;
    pready && pwrite && (paddr == `CSP_ADDR_CTRL1) && pwdata[`CSP_C1_ABORT] |-> ##[1:2] !sclkOe;
  endproperty
  a_abortStop: assert property (p_abortStop) else $error("abort left clock driven");
  c_done: cover property (doneIrq);
  c_err: cover property (pready && pslverr);
  c_stop: cover property ($fell(sclkOe));
endmodule
bind csp_top csp_top_properties chk_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sclkIn(sclkIn), .sclkOut(sclkOut), .sclkOe(sclkOe), .sdi(sdi),
  .sdo(sdo), .doneIrq(doneIrq));

// File: csp_peer.sv
// serial partner: shifts data in and out on the serial clock
`timescale 1ns/1ps
module csp_peer (
  input  wire sclk,
  input  wire drive,
  input  wire sdo,
  output wire sdi
);
  reg [7:0]  txWord = 8'h00;
  reg [15:0] rxWord = 16'h0000;
  reg [2:0]  idx = 3'h0;
  reg        bitOut = 1'b1;
  always @(negedge sclk) bitOut <= txWord[idx];
  always @(posedge sclk) begin
    rxWord <= {sdo, rxWord[15:1]};
    idx <= idx + 3'h1;
  end
  // while drive is low (idle or external clock) the line shows the inverse
  assign sdi = drive ? bitOut : ~bitOut;
endmodule

// File: csp_top_tb.sv
// testbench of the clocked serial port
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; $display("Error %s exp %h got %h", n, e, g); end end
module csp_top_tb;
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [7:0]  paddr = 8'h00;
  reg  [31:0] pwdata = 32'h0;
  reg  [31:0] rd;
  reg         err;
  wire [31:0] prdata;
  wire        pready, pslverr, sclkOut, sclkOe, sdi, sdo, doneIrq;
  reg         extClk = 1'b1;
  wire        sclk = sclkOe ? sclkOut : extClk;
  integer     fail_count = 0;
  integer     checked = 0;
  integer     n;
  csp_top dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sclkIn(sclk), .sclkOut(sclkOut), .sclkOe(sclkOe), .sdi(sdi), .sdo(sdo), .doneIrq(doneIrq));
  csp_peer peer_u (.sclk(sclk), .drive(sclkOe), .sdo(sdo), .sdi(sdi));
  initial forever #2.5 clk = ~clk;
  task apb(input [7:0] a, input w, input [7:0] d);
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      @(posedge clk);
      while (pready !== 1'b1 && n < 50) begin
        n = n + 1;
        @(posedge clk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // external pulses sixteen clocks wide, idle high
  task extPulse(input integer cnt);
    begin
      repeat (cnt) begin
        @(posedge clk);
        extClk <= 1'b0;
        repeat (16) @(posedge clk);
        extClk <= 1'b1;
        repeat (15) @(posedge clk);
      end
      repeat (8) @(posedge clk);
    end
  endtask
  task waitDone;
    begin
      n = 0;
      while (doneIrq !== 1'b1 && n < 3000) begin
        @(posedge clk);
        n = n + 1;
      end
      `CHK("doneIrq", 1'b1, doneIrq)
    end
  endtask
  task waitIdle;
    begin
      for (int k = 0; k < 100; k++) begin
        apb(8'h08, 1'b0, 8'h00);
        if (rd[7] === 1'b0) break;
      end
      `CHK("active", 1'b0, rd[7])
    end
  endtask
  task results;
    begin
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    results;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    apb(8'h08, 1'b0, 8'h00);
    `CHK("status", 8'h00, rd[7:0])
    apb(8'h0C, 1'b0, 8'h00);
    `CHK("unmapped", 1'b1, err)
    apb(8'h20, 1'b1, 8'hA5);
    apb(8'h24, 1'b1, 8'h3C);
    apb(8'h04, 1'b1, 8'h01);
    apb(8'h04, 1'b0, 8'h00);
    `CHK("count", 32'h1, rd)
    apb(8'h00, 1'b1, 8'h05);
    apb(8'h00, 1'b1, 8'h85);
    apb(8'h08, 1'b0, 8'h00);
    `CHK("active", 1'b1, rd[7])
    waitDone;
    `CHK("tx words", 16'h3CA5, peer_u.rxWord)
    peer_u.rxWord = 16'h0000;
    repeat (100) @(posedge clk);
    `CHK("wait", 16'h0000, peer_u.rxWord)
    apb(8'h3C, 1'b1, 8'h77);
    waitDone;
    `CHK("resend", 16'h3CA5, peer_u.rxWord)
    apb(8'h00, 1'b1, 8'h05);
    waitIdle;
    apb(8'h00, 1'b1, 8'h35);
    apb(8'h24, 1'b0, 8'h00);
    `CHK("mode clear", 8'h00, rd[7:0])
    apb(8'h04, 1'b1, 8'h00);
    peer_u.txWord = 8'hC3;
    peer_u.idx = 3'h0;
    apb(8'h00, 1'b1, 8'hB5);
    waitDone;
    apb(8'h20, 1'b0, 8'h00);
    `CHK("rx nibble", 8'h03, rd[7:0])
    apb(8'h00, 1'b1, 8'h35);
    waitIdle;
    apb(8'h00, 1'b1, 8'h06);
    apb(8'h00, 1'b1, 8'h86);
    apb(8'h08, 1'b0, 8'h00);
    `CHK("code 110", 1'b0, rd[7])
    apb(8'h04, 1'b1, 8'h07);
    apb(8'h00, 1'b1, 8'h85);
    repeat (40) @(posedge clk);
    apb(8'h00, 1'b1, 8'h45);
    apb(8'h08, 1'b0, 8'h00);
    `CHK("abort", 1'b0, rd[7])
    apb(8'h00, 1'b1, 8'h07);
    apb(8'h04, 1'b1, 8'h00);
    apb(8'h20, 1'b1, 8'h5A);
    peer_u.rxWord = 16'h0000;
    apb(8'h00, 1'b1, 8'h87);
    extPulse(16);
    `CHK("ext dummy", 16'hFF5A, peer_u.rxWord)
    apb(8'h08, 1'b0, 8'h00);
    `CHK("ext end", 1'b0, rd[7])
    results;
  end
endmodule
